// ---- common/sci_defs.vh ----
// Register addresses, field positions, reset values and divider figures
`ifndef SCI_DEFS_VH
`define SCI_DEFS_VH

`define SCI_CFG_IRQ_CLK_ADDR 8'h13
`define SCI_CFG_SERIAL_ADDR 8'h14
`define SCI_OUT_TX_DATA_ADDR 8'h09
`define SCI_IN_RX_DATA_ADDR 8'h12
`define SCI_IN_STATUS_ADDR 8'h13

`define SCI_SER_TX_ON 0
`define SCI_SER_RX_ON 1
`define SCI_SER_LAYOUT_LO 2
`define SCI_SER_LAYOUT_HI 3
`define SCI_SER_NINTH 4
`define SCI_SER_RATE_LO 5
`define SCI_SER_RATE_HI 7

`define SCI_IRQ_FREQ_LO 1
`define SCI_IRQ_FREQ_HI 2
`define SCI_IRQ_EN_LO 3
`define SCI_IRQ_EN_HI 7
`define SCI_IRQ_CFG_MASK 8'hFE

`define SCI_ST_RX_FULL 0
`define SCI_ST_LOST 1
`define SCI_ST_FRAME 2
`define SCI_ST_NOISE 3
`define SCI_ST_TX_EMPTY 4
`define SCI_ST_TX_DONE 5
`define SCI_ST_BREAK 6

`define SCI_LAYOUT_8N1 2'h0
`define SCI_LAYOUT_8N2 2'h1
`define SCI_LAYOUT_8P1 2'h2
`define SCI_LAYOUT_9N1 2'h3

`define SCI_FREQ_5A 2'h0
`define SCI_FREQ_10 2'h1
`define SCI_FREQ_20 2'h2

`define SCI_SER_RESET 8'h00
`define SCI_IRQ_CFG_RESET 8'h00

`define SCI_OVERSAMPLE 16
`define SCI_SLOWEST_BAUD 600
`define SCI_MCLK_5_HZ 5000000
`define SCI_MCLK_10_HZ 10000000
`define SCI_MCLK_20_HZ 20000000
`define SCI_BASE_TICK_HZ (`SCI_SLOWEST_BAUD * `SCI_OVERSAMPLE)
`define SCI_DIV_5 ((`SCI_MCLK_5_HZ + `SCI_BASE_TICK_HZ / 2) / `SCI_BASE_TICK_HZ)
`define SCI_DIV_10 ((`SCI_MCLK_10_HZ + `SCI_BASE_TICK_HZ / 2) / `SCI_BASE_TICK_HZ)
`define SCI_DIV_20 ((`SCI_MCLK_20_HZ + `SCI_BASE_TICK_HZ / 2) / `SCI_BASE_TICK_HZ)
`define SCI_RATE_UNUSED 3'h7

`define SCI_FRAME_BITS_SHORT 4'hA
`define SCI_FRAME_BITS_LONG 4'hB

`endif

// ---- logic/async_serial_rx_buffer_tx_baud.v ----
// Serial holding buffers, transmitter and baud-rate generator
`timescale 1ns/100ps
`include "sci_defs.vh"

module async_serial_rx_buffer_tx_baud #(
    parameter DATA_BITS = 9
) (
    input wire clk_in,
    input wire nrst_in,
    input wire cfg_wr_in,
    input wire [7:0] cfg_addr_in,
    input wire [7:0] cfg_data_in,
    input wire out_wr_in,
    input wire [7:0] out_addr_in,
    input wire [7:0] out_data_in,
    input wire in_rd_in,
    input wire [7:0] in_addr_in,
    output reg [7:0] in_data_out,
    input wire rx_done_in,
    input wire [DATA_BITS-1:0] rx_word_in,
    input wire rx_frame_err_in,
    input wire rx_noise_err_in,
    input wire rx_break_in,
    output reg rx_tick_out,
    output wire rx_on_out,
    output wire [1:0] word_layout_out,
    output wire ninth_bit_parity_sel_out,
    output reg tx_line_out,
    output wire [4:0] irq_req_out
);

    localparam TX_IDLE = 3'b001;
    localparam TX_WAIT = 3'b010;
    localparam TX_SEND = 3'b100;

    reg [7:0] serial_cfg;
    reg [7:0] serial_irq_and_clock_config;
    reg [DATA_BITS-1:0] receive_holding_buffer;
    reg rx_full_flag;
    reg frame_fault_flag;
    reg noise_fault_flag;
    reg receive_lost_flag;
    reg break_seen_flag;
    reg [7:0] transmit_holding_buffer;
    reg tx_holding_empty;
    reg tx_shift_done;
    reg [2:0] tx_state;
    reg [11:0] tx_shift;
    reg [3:0] tx_bits_left;
    reg [11:0] tick_cnt;
    reg [3:0] sub_cnt;
    reg bit_tick;

    wire tx_on;
    wire rx_on;
    wire [1:0] word_layout;
    wire ninth_bit_parity_sel;
    wire [2:0] bit_rate_sel;
    wire [1:0] master_clock_freq_sel;
    wire end_of_tx_irq_en;
    wire tx_empty_irq_en;
    wire break_irq_en;
    wire lost_data_irq_en;
    wire rx_full_irq_en;
    wire [11:0] tick_div;
    wire rx_data_read;
    wire status_read;
    wire tx_write;
    wire shifter_load;
    wire extra_bit;
    wire [7:0] status_word;

    // Decodes the master-clock field into the divisor for the slowest rate
    function [11:0] base_divisor;
        input [1:0] freq;
        reg [31:0] full_div;
        begin
            case (freq)
                `SCI_FREQ_10: full_div = `SCI_DIV_10;
                `SCI_FREQ_20: full_div = `SCI_DIV_20;
                default: full_div = `SCI_DIV_5;
            endcase
            // Largest divisor fits in twelve bits
            base_divisor = full_div[11:0];
        end
    endfunction

    // Bit that follows the eight data bits for a given layout
    function ninth_bit;
        input [1:0] layout;
        input sel;
        input [7:0] data;
        begin
            case (layout)
                `SCI_LAYOUT_8P1: ninth_bit = sel ? ^data : ~^data;
                `SCI_LAYOUT_9N1: ninth_bit = sel;
                default: ninth_bit = 1'b1;
            endcase
        end
    endfunction

    assign tx_on = serial_cfg[`SCI_SER_TX_ON];
    assign rx_on = serial_cfg[`SCI_SER_RX_ON];
    assign word_layout = serial_cfg[`SCI_SER_LAYOUT_HI:`SCI_SER_LAYOUT_LO];
    assign ninth_bit_parity_sel = serial_cfg[`SCI_SER_NINTH];
    assign bit_rate_sel = serial_cfg[`SCI_SER_RATE_HI:`SCI_SER_RATE_LO];
    assign master_clock_freq_sel =
        serial_irq_and_clock_config[`SCI_IRQ_FREQ_HI:`SCI_IRQ_FREQ_LO];
    assign end_of_tx_irq_en = serial_irq_and_clock_config[3];
    assign tx_empty_irq_en = serial_irq_and_clock_config[4];
    assign break_irq_en = serial_irq_and_clock_config[5];
    assign lost_data_irq_en = serial_irq_and_clock_config[6];
    assign rx_full_irq_en = serial_irq_and_clock_config[7];

    assign rx_on_out = rx_on;
    assign word_layout_out = word_layout;
    assign ninth_bit_parity_sel_out = ninth_bit_parity_sel;

    assign irq_req_out = {rx_full_irq_en & rx_full_flag,
                          lost_data_irq_en & receive_lost_flag,
                          break_irq_en & break_seen_flag,
                          tx_empty_irq_en & tx_holding_empty,
                          end_of_tx_irq_en & tx_shift_done};

    assign rx_data_read = in_rd_in && (in_addr_in == `SCI_IN_RX_DATA_ADDR);
    assign status_read = in_rd_in && (in_addr_in == `SCI_IN_STATUS_ADDR);
    // write accepted only when empty and enabled
    assign tx_write = out_wr_in && (out_addr_in == `SCI_OUT_TX_DATA_ADDR) &&
                      tx_on && tx_holding_empty;
    // no new word once tx on drops
    assign shifter_load = (tx_state == TX_IDLE) && tx_on && !tx_holding_empty &&
                          tx_shift_done;

    assign extra_bit = ninth_bit(word_layout, ninth_bit_parity_sel,
                                 transmit_holding_buffer);

    assign status_word = {1'b0, break_seen_flag, tx_shift_done, tx_holding_empty,
                          noise_fault_flag, frame_fault_flag, receive_lost_flag,
                          rx_full_flag};

    assign tick_div = base_divisor(master_clock_freq_sel) >> bit_rate_sel;

    // Configuration registers
    always @(posedge clk_in) begin
        if (!nrst_in) begin
            serial_cfg <= `SCI_SER_RESET;
            serial_irq_and_clock_config <= `SCI_IRQ_CFG_RESET;
        end else if (cfg_wr_in) begin
            if (cfg_addr_in == `SCI_CFG_SERIAL_ADDR) begin
                serial_cfg <= cfg_data_in;
            end
            if (cfg_addr_in == `SCI_CFG_IRQ_CLK_ADDR) begin
                serial_irq_and_clock_config <= cfg_data_in & `SCI_IRQ_CFG_MASK;
            end
        end
    end

    // oversample tick, bit tick every sixteenth
    always @(posedge clk_in) begin
        if (!nrst_in) begin
            tick_cnt <= 12'h000;
            sub_cnt <= 4'h0;
            rx_tick_out <= 1'b0;
            bit_tick <= 1'b0;
        end else if (bit_rate_sel == `SCI_RATE_UNUSED) begin
            // Unused rate code stops both clocks
            tick_cnt <= 12'h000;
            sub_cnt <= 4'h0;
            rx_tick_out <= 1'b0;
            bit_tick <= 1'b0;
        end else if (tick_cnt >= tick_div - 12'h001) begin
            tick_cnt <= 12'h000;
            sub_cnt <= sub_cnt + 4'h1;
            rx_tick_out <= 1'b1;
            bit_tick <= (sub_cnt == 4'hF);
        end else begin
            tick_cnt <= tick_cnt + 12'h001;
            rx_tick_out <= 1'b0;
            bit_tick <= 1'b0;
        end
    end

    // Receive holding buffer and its flags
    always @(posedge clk_in) begin
        if (!nrst_in) begin
            receive_holding_buffer <= {DATA_BITS{1'b0}};
            rx_full_flag <= 1'b0;
            frame_fault_flag <= 1'b0;
            noise_fault_flag <= 1'b0;
            receive_lost_flag <= 1'b0;
            break_seen_flag <= 1'b0;
        end else begin
            if (status_read) begin
                receive_lost_flag <= 1'b0;
                break_seen_flag <= 1'b0;
            end
            if (rx_data_read) begin
                rx_full_flag <= 1'b0;
            end
            if (rx_done_in && rx_on) begin
                if (rx_full_flag && !rx_data_read) begin
                    receive_lost_flag <= 1'b1;
                end else begin
                    receive_holding_buffer <= rx_word_in;
                    frame_fault_flag <= rx_frame_err_in;
                    noise_fault_flag <= rx_noise_err_in;
                    rx_full_flag <= 1'b1;
                end
            end
            // Set wins over a status read in the same cycle
            if (rx_break_in && rx_on) begin
                break_seen_flag <= 1'b1;
            end
        end
    end

    // Read data path
    always @(posedge clk_in) begin
        if (!nrst_in) begin
            in_data_out <= 8'h00;
        end else if (rx_data_read) begin
            in_data_out <= receive_holding_buffer[7:0];
        end else if (status_read) begin
            in_data_out <= status_word;
        end
    end

    // Transmit holding buffer
    always @(posedge clk_in) begin
        if (!nrst_in) begin
            transmit_holding_buffer <= 8'h00;
            tx_holding_empty <= 1'b1;
        end else if (tx_write) begin
            transmit_holding_buffer <= out_data_in;
            tx_holding_empty <= 1'b0;
        end else if (shifter_load) begin
            tx_holding_empty <= 1'b1;
        end
    end

    // Shifter; frames start on a bit tick
    always @(posedge clk_in) begin
        if (!nrst_in) begin
            tx_state <= TX_IDLE;
            tx_shift <= 12'hFFF;
            tx_bits_left <= 4'h0;
            tx_shift_done <= 1'b1;
            tx_line_out <= 1'b1;
        end else begin
            case (tx_state)
                TX_IDLE: begin
                    tx_line_out <= 1'b1;
                    if (shifter_load) begin
                        // stop bits; layout sets the length
                        tx_shift <= {2'b11, extra_bit, transmit_holding_buffer, 1'b0};
                        if (word_layout == `SCI_LAYOUT_8N1) begin
                            tx_bits_left <= `SCI_FRAME_BITS_SHORT;
                        end else begin
                            tx_bits_left <= `SCI_FRAME_BITS_LONG;
                        end
                        tx_shift_done <= 1'b0;
                        tx_state <= TX_WAIT;
                    end
                end
                TX_WAIT: begin
                    // start waits a bit tick, one idle bit after done
                    if (bit_tick) begin
                        tx_line_out <= tx_shift[0];
                        tx_shift <= {1'b1, tx_shift[11:1]};
                        tx_bits_left <= tx_bits_left - 4'h1;
                        tx_state <= TX_SEND;
                    end
                end
                TX_SEND: begin
                    if (bit_tick) begin
                        if (tx_bits_left == 4'h0) begin
                            tx_shift_done <= 1'b1;
                            tx_line_out <= 1'b1;
                            tx_state <= TX_IDLE;
                        end else begin
                            tx_line_out <= tx_shift[0];
                            tx_shift <= {1'b1, tx_shift[11:1]};
                            tx_bits_left <= tx_bits_left - 4'h1;
                        end
                    end
                end
                default: begin
                    tx_state <= TX_IDLE;
                    tx_line_out <= 1'b1;
                end
            endcase
        end
    end

endmodule // async_serial_rx_buffer_tx_baud

// ---- verif/serial_block_properties.sv ----
// Port-level checker for the serial buffer and transmitter block
`timescale 1ns/100ps
module serial_block_checker #(
    parameter DATA_BITS = 9
) (
    input wire clk_in,
    input wire nrst_in,
    input wire cfg_wr_in,
    input wire [7:0] cfg_addr_in,
    input wire [7:0] cfg_data_in,
    input wire in_rd_in,
    input wire [7:0] in_addr_in,
    input wire [7:0] in_data_out,
    input wire rx_done_in,
    input wire [DATA_BITS-1:0] rx_word_in,
    input wire rx_tick_out,
    input wire rx_on_out,
    input wire [1:0] word_layout_out,
    input wire ninth_bit_parity_sel_out,
    input wire tx_line_out,
    input wire [4:0] irq_req_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    property p_reset_idle;
        @(posedge clk_in) disable iff (1'b0)
        !nrst_in |=> tx_line_out && irq_req_out == 5'h00 && in_data_out == 8'h00;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("reset values wrong");
    property p_cfg_echo;
        cfg_wr_in && cfg_addr_in == 8'h14 |=>
            {ninth_bit_parity_sel_out, word_layout_out, rx_on_out} == $past(cfg_data_in[4:1]);
    endproperty
    a_cfg_echo: assert property (p_cfg_echo) else $error("serial config fields");
    property p_rx_load;
        in_rd_in && in_addr_in == 8'h12 && !rx_done_in ##1 rx_done_in && rx_on_out && !in_rd_in
            ##1 in_rd_in && in_addr_in == 8'h12 |=> in_data_out == $past(rx_word_in[7:0], 2);
    endproperty
    a_rx_load: assert property (p_rx_load) else $error("received word not loaded");
    property p_rx_clear;
        in_rd_in && in_addr_in == 8'h12 && !rx_done_in
            ##1 in_rd_in && in_addr_in == 8'h13 && !rx_done_in |=> !in_data_out[0];
    endproperty
    a_rx_clear: assert property (p_rx_clear) else $error("full flag not cleared");
    property p_overrun;
        rx_done_in && rx_on_out && !(in_rd_in && in_addr_in == 8'h12)
            ##1 rx_done_in && rx_on_out && !(in_rd_in && in_addr_in == 8'h12)
            ##1 in_rd_in && in_addr_in == 8'h13 |=> in_data_out[1];
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged");
    property p_irq_off;
        cfg_wr_in && cfg_addr_in == 8'h13 && cfg_data_in[7:3] == 5'h00 |=> irq_req_out == 5'h00;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("masked request seen");
    property p_tick_pulse;
        rx_tick_out |=> !rx_tick_out;
    endproperty
    a_tick_pulse: assert property (p_tick_pulse) else $error("sampling tick too long");
    property p_line_hold;
        $changed(tx_line_out) |=> $stable(tx_line_out) [*7];
    endproperty
    a_line_hold: assert property (p_line_hold) else $error("line bit too short");
endmodule // serial_block_checker

bind async_serial_rx_buffer_tx_baud serial_block_checker #(.DATA_BITS(DATA_BITS)) u_chk (.*);

// ---- verif/remote_uart_model.sv ----
// Far-end receiver that decodes frames from the serial line
`timescale 1ns/100ps
module remote_uart_model #(
    parameter int BIT = 512
) (
    input wire clk_in,
    input wire line_in,
    output logic [9:0] bits_out,
    output int frames_out,
    output int gap_out
);
    int cyc = 0;
    int last = 0;
    always @(posedge clk_in) cyc <= cyc + 1;
    // Mid-bit sampling: ten bits after start, stop or idle last
    initial begin
        bits_out = 10'h000;
        frames_out = 0;
        gap_out = 0;
        forever begin
            @(negedge line_in);
            gap_out = cyc - last;
            last = cyc;
            repeat (BIT / 2) @(posedge clk_in);
            for (int i = 0; i < 10; i++) begin
                repeat (BIT) @(posedge clk_in);
                bits_out[i] = line_in;
            end
            frames_out++;
        end
    end
endmodule // remote_uart_model

// ---- verif/tb_top.sv ----
// Self-checking testbench for the serial buffer and transmitter block
`timescale 1ns/100ps
`include "sci_defs.vh"
module tb_top;
    // Fastest rate at 20 MHz keeps frames short
    localparam int BIT = 16 * (`SCI_DIV_20 >> 6);
    logic clk_in = 1'h0, nrst_in = 1'h0, cfg_wr_in = 1'h0, out_wr_in = 1'h0, in_rd_in = 1'h0;
    logic rx_done_in = 1'h0, rx_frame_err_in = 1'h0, rx_noise_err_in = 1'h0, rx_break_in = 1'h0;
    logic [7:0] cfg_addr_in = 8'h00, cfg_data_in = 8'h00, out_addr_in = 8'h00;
    logic [7:0] out_data_in = 8'h00, in_addr_in = 8'h00, s;
    logic [8:0] rx_word_in = 9'h000;
    wire [7:0] in_data_out;
    wire rx_tick_out, rx_on_out, ninth_bit_parity_sel_out, tx_line_out;
    wire [1:0] word_layout_out;
    wire [4:0] irq_req_out;
    wire [9:0] rbits;
    int frames, gap, n, ticks, err_total = 0, checks_done = 0;
    async_serial_rx_buffer_tx_baud #(.DATA_BITS(9)) u_dut (.*);
    remote_uart_model #(.BIT(BIT)) u_far (.clk_in(clk_in), .line_in(tx_line_out),
        .bits_out(rbits), .frames_out(frames), .gap_out(gap));
    initial forever #12.5 clk_in = ~clk_in;
    // Strobes stay up until the next call or tick; no double drive in one step
    task strobes(input logic [3:0] v);
        {cfg_wr_in, out_wr_in, in_rd_in, rx_done_in} = v;
    endtask
    task edge2; @(posedge clk_in); #2; endtask
    task tick; strobes(4'h0); edge2; endtask
    task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask
    task cfg_wr(input logic [7:0] a, input logic [7:0] d);
        strobes(4'h8); cfg_addr_in = a; cfg_data_in = d; edge2;
    endtask
    task tx_wr(input logic [7:0] d);
        strobes(4'h4); out_addr_in = 8'h09; out_data_in = d; edge2;
    endtask
    task rd(input logic [7:0] a);
        strobes(4'h2); in_addr_in = a; edge2; s = in_data_out;
    endtask
    task pulse(input logic [8:0] w, input logic fe, input logic ne);
        strobes(4'h1); rx_word_in = w; rx_frame_err_in = fe; rx_noise_err_in = ne; edge2;
    endtask
    task wait_frames(input int want);
        for (int k = 0; k < 20 * BIT && frames < want; k++) tick;
        check(frames, want, "frame count");
    endtask
    task t_reset_idle;
        cfg_wr(8'h13, 8'h04); tx_wr(8'h5A); rd(8'h13);
        check(s[4], 1'h1, "empty before enable");
        repeat (2 * BIT) tick;
        check(frames, 0, "no frame before enable");
    endtask
    task t_receive;
        cfg_wr(8'h14, 8'hC3); cfg_wr(8'h13, 8'hD4); rd(8'h12);
        pulse(9'h1A5, 1'h1, 1'h0); rd(8'h12);
        check(s, 8'hA5, "rx data");
        rd(8'h13);
        check(s[3:0], 4'h4, "flags after read");
        pulse(9'h033, 1'h0, 1'h1); pulse(9'h044, 1'h0, 1'h0);
        check(irq_req_out, 5'h1A, "irq full overrun empty");
        rd(8'h13);
        check(s[1:0], 2'h3, "overrun and full");
        rd(8'h12);
        check(s, 8'h33, "first word kept");
        check(irq_req_out, 5'h02, "irq after reads");
        cfg_wr(8'h13, 8'h2C); rx_break_in = 1'h1; tick; rx_break_in = 1'h0;
        check(irq_req_out, 5'h05, "irq break and end of tx");
        rd(8'h13);
        check(s[6], 1'h1, "break seen");
        check(irq_req_out, 5'h01, "break cleared by status read");
        cfg_wr(8'h14, 8'hC1); pulse(9'h0EE, 1'h0, 1'h0); rd(8'h13);
        check(s[0], 1'h0, "receiver off ignores word");
    endtask
    task t_formats;
        logic [1:0] lay [6] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
        logic [7:0] d;
        logic nb;
        for (int i = 0; i < 6; i++) begin
            d = 8'h35 + 8'h11 * i[7:0];
            nb = (lay[i] == 2'h2) ? (i[0] ? ^d : ~^d) : (lay[i] == 2'h3) ? i[0] : 1'h1;
            cfg_wr(8'h14, {3'h6, i[0], lay[i], 2'h3}); n = frames; tx_wr(d); rd(8'h13);
            check(s[4], 1'h0, "holding full");
            repeat (BIT) tick; rd(8'h13);
            check(s[5:4], 2'h1, "shifting");
            wait_frames(n + 1);
            check(rbits, {1'h1, nb, d}, "frame bits");
            rd(8'h13);
            check(s[5], lay[i] == 2'h0, "done by frame length");
            repeat (2 * BIT) tick; rd(8'h13);
            check(s[5], 1'h1, "shift done");
        end
    endtask
    task t_back_to_back;
        cfg_wr(8'h14, 8'hC3); n = frames;
        tx_wr(8'h11); tick; rd(8'h13);
        // Pace by the empty flag while the shifter is busy
        check(s[5:4], 2'h1, "holding free while shifting");
        // Third write lands while the holding buffer is full
        tx_wr(8'h22); tx_wr(8'h33);
        ticks = 0;
        repeat (BIT) begin
            tick;
            ticks += rx_tick_out;
        end
        check(ticks, 16, "sampling ticks per bit");
        wait_frames(n + 1);
        check(rbits[7:0], 8'h11, "first word");
        wait_frames(n + 2);
        check(rbits[7:0], 8'h22, "second word");
        check(gap, 11 * BIT, "start spacing");
        repeat (13 * BIT) tick;
        check(frames, n + 2, "refused word not sent");
    endtask
    task t_stop_mid;
        // Second word waits in the holding buffer when tx on drops
        n = frames; tx_wr(8'h5C); tick; tx_wr(8'h77); repeat (3 * BIT) tick;
        cfg_wr(8'h14, 8'hC2);
        wait_frames(n + 1);
        check(rbits, 10'h35C, "frame finished");
        repeat (13 * BIT) tick;
        check(frames, n + 1, "stopped after frame");
        rd(8'h13);
        check(s[4], 1'h0, "held word not sent");
    endtask
    task complete_run;
        $display("checks %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (5) tick;
        nrst_in = 1'h1;
        t_reset_idle;
        t_receive;
        t_formats;
        t_back_to_back;
        t_stop_mid;
        complete_run;
    end
    // Run needs about 71k cycles; the 160k-cycle limit is over twice that
    initial begin
        #4000000;
        err_total++;
        complete_run;
    end
endmodule // tb_top
